// file: pkg/prcc_pkg.sv
// Constants, types and helpers of the periodic report channel controller
// What this block does
// - Code 07da sets up a report channel
// - Channel 1 to 32, else command error
// - Setup on busy channel reassigns it
// - Count of sends, zero sends forever
// - Unit code times count gives period
// - Period timing runs even for one send
// - One send at each period start
// - Late transfer flags non-fatal period error
// - Next send waits for pending completion
// - Single send has one outstanding transfer
// - Zero count sends back to back
// - Timeout in hundredths, zero disables it
// - Source memory type decoded from codes
// - Start address is one-based
// - Length limited per bit, byte, word
// - Code 07d1 aborts, stopped before success
// - Abort idles channel and clears flags
// - Channel ffff aborts all, never error
// - Abort answers at once, no traffic
// - First send at once after setup
// - Channel error is control register bit 9
package prcc_pkg;
  localparam int          NUM_CH        = 32;
  localparam logic [15:0] CMD_SETUP     = 16'h07da;
  localparam logic [15:0] CMD_ABORT     = 16'h07d1;
  localparam logic [15:0] CHAN_ALL      = 16'hffff;
  // Command words 7..23 as indices
  localparam int W_CMD = 0, W_CHAN = 1, W_REPS = 2, W_UNIT = 3, W_CNT = 4, W_TMO = 5;
  localparam int W_MEM = 6, W_START = 7, W_LEN = 8, W_ATYPE = 11, W_ALEN = 12, W_IP0 = 13;
  localparam int NUM_WORDS = 17;
  // Register byte offsets
  localparam logic [7:0] OFF_WORD0  = 8'h00;
  localparam logic [7:0] OFF_GO     = 8'h44;
  localparam logic [7:0] OFF_STATUS = 8'h48;
  localparam logic [7:0] OFF_CTRL   = 8'h4c;
  localparam logic [7:0] OFF_XFER   = 8'h50;
  localparam logic [7:0] OFF_ERR    = 8'h54;
  localparam logic [7:0] OFF_DSEL   = 8'h58;
  localparam logic [7:0] OFF_DETAIL = 8'h5c;
  localparam int         CTRL_ERR_BIT = 9;
  // Completion and detailed status codes
  localparam logic [15:0] STAT_IDLE      = 16'h0000;
  localparam logic [15:0] STAT_OK        = 16'h0001;
  localparam logic [15:0] STAT_CMD_ERR   = 16'h0004;
  localparam logic [15:0] STAT_PARAM_ERR = 16'h0008;
  localparam logic [15:0] DET_PERIOD_ERR = 16'h0111;
  localparam logic [15:0] DET_TMO_ERR    = 16'h0211;
  // Time units and their length in hundredths of a second
  localparam logic [15:0] UNIT_HUNDREDTH = 16'h0001, UNIT_TENTH = 16'h0002, UNIT_SEC = 16'h0003;
  localparam logic [15:0] UNIT_MIN = 16'h0004, UNIT_HOUR = 16'h0005;
  localparam logic [18:0] MUL_HUNDREDTH = 19'h00001, MUL_TENTH = 19'h0000a, MUL_SEC = 19'h00064;
  localparam logic [18:0] MUL_MIN = 19'h01770, MUL_HOUR = 19'h57e40;
  localparam int          PER_W = 35;
  // Memory types and length limits
  localparam logic [15:0] MT_R = 16'h0008, MT_AI = 16'h000a, MT_AQ = 16'h000c;
  localparam logic [15:0] MT_BYTE_LO = 16'h0010, MT_BYTE_HI = 16'h001e, MT_G_BYTE = 16'h0038;
  localparam logic [15:0] MT_BIT_LO = 16'h0046, MT_BIT_HI = 16'h0056;
  localparam logic [15:0] MAX_BITS = 16'h4000, MAX_BYTES = 16'h0800, MAX_WORDS = 16'h0400;
  localparam logic [15:0] ADDR_TYPE_IP = 16'h0001, ADDR_LEN_IP = 16'h0004;
  // Hundredth-second tick
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_TIME_US  = 10000;
  localparam int TICK_CYCLES   = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK_W        = 17;

  typedef enum logic [1:0] {PRCC_MT_BAD, PRCC_MT_WORD, PRCC_MT_BYTE, PRCC_MT_BIT} prcc_mclass_t;

  typedef struct packed {
    logic [4:0]  channel;
    logic [7:0]  mem_type;
    logic [15:0] start;
    logic [15:0] length;
    logic [31:0] ip;
  } prcc_req_t;

  function automatic prcc_mclass_t prcc_mem_class(input logic [15:0] mt);
    if (mt == MT_R || mt == MT_AI || mt == MT_AQ)
      return PRCC_MT_WORD;
    if ((mt >= MT_BYTE_LO && mt <= MT_BYTE_HI && !mt[0]) || mt == MT_G_BYTE)
      return PRCC_MT_BYTE;
    if (mt >= MT_BIT_LO && mt <= MT_BIT_HI && !mt[0])
      return PRCC_MT_BIT;
    return PRCC_MT_BAD;
  endfunction

  function automatic logic [18:0] prcc_unit_mul(input logic [15:0] unit);
    case (unit)
      UNIT_HUNDREDTH: return MUL_HUNDREDTH;
      UNIT_TENTH:     return MUL_TENTH;
      UNIT_SEC:       return MUL_SEC;
      UNIT_MIN:       return MUL_MIN;
      UNIT_HOUR:      return MUL_HOUR;
      default:        return 19'h00000;
    endcase
  endfunction
endpackage

// file: verilog/prcc_top.sv
// Periodic report channel controller with APB command registers
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module prcc_top #(
  parameter int TICK_CYCLES = prcc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                REF_CLK_IN,
  input  wire logic                RESET_IN,
  // APB slave
  input  wire logic                PSEL_IN,
  input  wire logic                PENABLE_IN,
  input  wire logic                PWRITE_IN,
  input  wire logic [7:0]          PADDR_IN,
  input  wire logic [31:0]         PWDATA_IN,
  output logic [31:0]              PRDATA_OUT,
  output logic                     PREADY_OUT,
  output logic                     PSLVERR_OUT,
  // Transfer engine
  output prcc_pkg::prcc_req_t      XFER_REQ_OUT,
  output logic                     XFER_VALID_OUT,
  input  wire logic                XFER_READY_IN,
  input  wire logic                XFER_DONE_IN,
  input  wire logic [4:0]          XFER_DONE_CH_IN,
  output logic [31:0]              XFER_ABORT_OUT
);
  import prcc_pkg::*;

  logic [15:0]              cmd_word [NUM_WORDS];
  logic [15:0]              status;
  logic [4:0]               dsel;
  logic [31:0]              rdata;
  logic [TICK_W-1:0]        tick_cnt;
  logic                     tick;
  logic [7:0]               cfg_mem   [NUM_CH];
  logic [15:0]              cfg_start [NUM_CH];
  logic [15:0]              cfg_len   [NUM_CH];
  logic [31:0]              cfg_ip    [NUM_CH];
  logic [NUM_CH-1:0]        active_v, pending_v, want_v, err_v, xfer_v, per_exp_v;
  logic [NUM_CH-1:0]        setup_v, abort_v, done_v, grant_v, elig_v;
  logic [NUM_CH-1:0][15:0]  code_v;
  logic [4:0]               pick;
  logic                     load;

  // Bus decode
  logic        wr_acc, rd_acc, rd_setup, go, mapped, xfer_clr;
  logic [15:0] cmd, chan;
  logic [4:0]  sel_idx;
  logic        is_setup, is_abort, chan_ok, chan_all, setup_ok, abort_ok;
  prcc_mclass_t mclass;
  logic [15:0] len_max;
  logic [PER_W-1:0] period_load;

  assign wr_acc   = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_acc   = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
  assign rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  assign mapped   = (PADDR_IN[1:0] == 2'b00) && (PADDR_IN <= OFF_DETAIL);
  assign go       = wr_acc && PADDR_IN == OFF_GO;
  assign xfer_clr = rd_acc && PADDR_IN == OFF_XFER;
  assign PREADY_OUT  = PSEL_IN & PENABLE_IN;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;

  always_ff @(posedge REF_CLK_IN) begin
    if (wr_acc && mapped && PADDR_IN < OFF_GO) begin
      cmd_word[PADDR_IN[6:2]] <= PWDATA_IN[15:0];
    end
  end

  // Command validation
  assign cmd      = cmd_word[W_CMD];
  assign chan     = cmd_word[W_CHAN];
  assign sel_idx  = chan[4:0] - 5'h01;
  assign chan_ok  = chan >= 16'h0001 && chan <= 16'(NUM_CH);
  assign chan_all = chan == CHAN_ALL;
  assign is_setup = cmd == CMD_SETUP;
  assign is_abort = cmd == CMD_ABORT;
  assign mclass   = prcc_mem_class(cmd_word[W_MEM]);

  always_comb begin
    unique case (mclass)
      PRCC_MT_WORD: len_max = MAX_WORDS;
      PRCC_MT_BYTE: len_max = MAX_BYTES;
      PRCC_MT_BIT:  len_max = MAX_BITS;
      PRCC_MT_BAD:  len_max = 16'h0000;
    endcase
  end

  assign period_load = PER_W'(prcc_unit_mul(cmd_word[W_UNIT])) * PER_W'(cmd_word[W_CNT]);
  assign setup_ok = chan_ok && mclass != PRCC_MT_BAD && cmd_word[W_LEN] != 16'h0000
                    && cmd_word[W_LEN] <= len_max && cmd_word[W_START] != 16'h0000
                    && prcc_unit_mul(cmd_word[W_UNIT]) != 19'h00000
                    && cmd_word[W_ATYPE] == ADDR_TYPE_IP && cmd_word[W_ALEN] == ADDR_LEN_IP;
  assign abort_ok = chan_ok || chan_all;

  assign setup_v = (go && is_setup && setup_ok) ? (NUM_CH'(1) << sel_idx) : '0;
  assign abort_v = (go && is_abort && chan_all) ? '1 :
                   (go && is_abort && chan_ok) ? (NUM_CH'(1) << sel_idx) : '0;
  assign done_v  = XFER_DONE_IN ? (NUM_CH'(1) << XFER_DONE_CH_IN) : '0;

  // Completion status answers in the cycle of the command
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      status <= STAT_IDLE;
    end else if (go) begin
      if (is_abort) begin
        status <= abort_ok ? STAT_OK : STAT_CMD_ERR;
      end else if (is_setup && !chan_ok) begin
        status <= STAT_CMD_ERR;
      end else if (is_setup && setup_ok) begin
        status <= STAT_OK;
      end else begin
        status <= STAT_PARAM_ERR;
      end
    end
  end

  // Per-channel transfer description
  always_ff @(posedge REF_CLK_IN) begin
    if (|setup_v) begin
      cfg_mem[sel_idx]   <= cmd_word[W_MEM][7:0];
      cfg_start[sel_idx] <= cmd_word[W_START] - 16'h0001;
      cfg_len[sel_idx]   <= cmd_word[W_LEN];
      cfg_ip[sel_idx]    <= {cmd_word[W_IP0][7:0], cmd_word[W_IP0 + 1][7:0],
                             cmd_word[W_IP0 + 2][7:0], cmd_word[W_IP0 + 3][7:0]};
    end
  end

  // Hundredth-second time base
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end
  assign tick = tick_cnt == TICK_W'(TICK_CYCLES - 1);

  // Channel engines
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [PER_W-1:0] per_cnt, per_cfg;
    logic [15:0]      tmo_cnt, tmo_cfg, left, code;
    logic             active, pending, want, err, xfer, fin, per_over;
    logic             per_end, tmo_end, last;

    assign per_end = tick && per_cnt == PER_W'(1);
    assign tmo_end = tick && pending && tmo_cnt == 16'h0001;
    assign last    = fin && left == 16'h0000;

    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
        {active, pending, want, err, fin, per_over} <= '0;
        per_cnt <= '0;
        per_cfg <= '0;
        tmo_cnt <= '0;
        tmo_cfg <= '0;
        left    <= '0;
        code    <= '0;
      end else if (abort_v[i]) begin
        {active, pending, want, err, fin, per_over} <= '0;
        per_cnt <= '0;
        tmo_cnt <= '0;
        code    <= '0;
      end else if (setup_v[i]) begin
        active   <= 1'b1;
        want     <= 1'b1;
        pending  <= 1'b0;
        err      <= 1'b0;
        per_over <= 1'b0;
        code     <= '0;
        per_cnt  <= '0;
        tmo_cnt  <= '0;
        per_cfg  <= period_load;
        tmo_cfg  <= cmd_word[W_TMO];
        left     <= cmd_word[W_REPS];
        fin      <= cmd_word[W_REPS] != 16'h0000;
      end else if (grant_v[i]) begin
        pending <= 1'b1;
        want    <= 1'b0;
        per_cnt <= per_cfg;
        tmo_cnt <= tmo_cfg;
        if (left != 16'h0000) begin
          left <= left - 16'h0001;
        end
      end else begin
        if (tick && per_cnt != '0) begin
          per_cnt <= per_cnt - PER_W'(1);
        end
        if (tick && pending && tmo_cnt != 16'h0000) begin
          tmo_cnt <= tmo_cnt - 16'h0001;
        end
        if (per_end) begin
          if (pending) begin
            err  <= 1'b1;
            code <= DET_PERIOD_ERR;
          end
          if (last) begin
            per_over <= 1'b1;
          end else begin
            want <= 1'b1;
          end
        end
        if (tmo_end) begin
          err  <= 1'b1;
          code <= DET_TMO_ERR;
        end
        if (done_v[i] && pending) begin
          pending <= 1'b0;
          if (per_cfg == '0 && !last) begin
            want <= 1'b1;
          end
        end
        if (active && last && !pending && (per_over || per_cfg == '0)) begin
          active   <= 1'b0;
          per_over <= 1'b0;
        end
      end
    end

    // Transfer bit: set by completion, cleared by reading, set wins
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
        xfer <= 1'b0;
      end else if (abort_v[i]) begin
        xfer <= 1'b0;
      end else if (done_v[i] && pending) begin
        xfer <= 1'b1;
      end else if (xfer_clr) begin
        xfer <= 1'b0;
      end
    end

    assign active_v[i]  = active;
    assign pending_v[i] = pending;
    assign want_v[i]    = want;
    assign err_v[i]     = err;
    assign xfer_v[i]    = xfer;
    assign code_v[i]    = code;
    assign per_exp_v[i] = per_end;
    assign elig_v[i]    = active && want && !pending && !abort_v[i] && !setup_v[i];
  end

  // Lowest eligible channel wins the engine
  always_comb begin
    pick = '0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (elig_v[k]) begin
        pick = 5'(k);
      end
    end
  end
  assign load    = (!XFER_VALID_OUT || XFER_READY_IN) && |elig_v;
  assign grant_v = load ? (NUM_CH'(1) << pick) : '0;

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      XFER_VALID_OUT <= 1'b0;
      XFER_REQ_OUT   <= '0;
    end else if (load) begin
      XFER_VALID_OUT <= 1'b1;
      XFER_REQ_OUT   <= '{channel: pick, mem_type: cfg_mem[pick], start: cfg_start[pick],
                          length: cfg_len[pick], ip: cfg_ip[pick]};
    end else if (XFER_READY_IN || abort_v[XFER_REQ_OUT.channel]) begin
      XFER_VALID_OUT <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      XFER_ABORT_OUT <= '0;
    end else begin
      XFER_ABORT_OUT <= abort_v;
    end
  end

  // Register reads, prepared in the setup phase
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      dsel <= '0;
    end else if (wr_acc && PADDR_IN == OFF_DSEL) begin
      dsel <= PWDATA_IN[4:0] - 5'h01;
    end
  end

  always_comb begin
    rdata = '0;
    if (PADDR_IN < OFF_GO && PADDR_IN[1:0] == 2'b00) begin
      rdata = {16'h0000, cmd_word[PADDR_IN[6:2]]};
    end else begin
      unique case (PADDR_IN)
        OFF_STATUS: rdata = {16'h0000, status};
        OFF_CTRL:   rdata = 32'(|err_v) << CTRL_ERR_BIT;
        OFF_XFER:   rdata = xfer_v;
        OFF_ERR:    rdata = err_v;
        OFF_DSEL:   rdata = {27'h0, dsel};
        OFF_DETAIL: rdata = {15'h0000, active_v[dsel], code_v[dsel]};
        default:    rdata = '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT <= '0;
    end else if (rd_setup) begin
      PRDATA_OUT <= mapped ? rdata : '0;
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  bad_chan_status_a: assert property (go && is_setup && !chan_ok |=> status == STAT_CMD_ERR)
    else $error("setup on bad channel not reported");
  setup_first_send_a: assert property (go && is_setup && setup_ok |=> active_v[$past(sel_idx)]
                                       && want_v[$past(sel_idx)] ##1 !want_v[$past(sel_idx, 2)]
                                       || pending_v[$past(sel_idx, 2)] || abort_v[$past(sel_idx, 2)])
    else $error("first send not issued at once");
  abort_clear_a: assert property (go && is_abort && chan_ok |=> !active_v[$past(sel_idx)]
                                  && !err_v[$past(sel_idx)] && code_v[$past(sel_idx)] == 16'h0000)
    else $error("abort left channel state");
  abort_all_a: assert property (go && is_abort && chan_all |=> active_v == '0 && status == STAT_OK)
    else $error("abort all failed");
  abort_now_a: assert property (go && is_abort |=> status != STAT_IDLE && XFER_ABORT_OUT == $past(abort_v))
    else $error("abort not answered at once");
  one_pending_a: assert property ((grant_v & pending_v) == '0 && $onehot0(grant_v))
    else $error("send issued over a pending transfer");
  period_err_a: assert property (|(per_exp_v & pending_v & ~abort_v & ~setup_v & ~grant_v) |=> |err_v)
    else $error("period overrun not flagged");
  err_bit9_a: assert property (rd_setup && PADDR_IN == OFF_CTRL |=> PRDATA_OUT[CTRL_ERR_BIT] == $past(|err_v))
    else $error("channel error not on bit 9");
  tick_space_a: assert property (tick |=> !tick [*8])
    else $error("time base tick too close");
  req_hold_a: assert property (XFER_VALID_OUT && !XFER_READY_IN && !(|abort_v)
                               |=> XFER_VALID_OUT && $stable(XFER_REQ_OUT))
    else $error("request changed before taken");

  setup_ok_c: cover property (go && is_setup && setup_ok);
  abort_all_c: cover property (go && is_abort && chan_all);
  period_err_c: cover property (|(per_exp_v & pending_v));
  xfer_taken_c: cover property (XFER_VALID_OUT && XFER_READY_IN ##[1:50] XFER_DONE_IN);
endmodule // prcc_top
`default_nettype wire

// file: sim/prcc_engine_model.sv
// Behavioural transfer engine facing the channel controller
`timescale 1ns/1ps
`default_nettype none
module prcc_engine_model (
  // Clock, reset and bench knobs
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic [15:0]   lat_in,
  input  wire logic          stall_in,
  // Request side
  input  wire prcc_pkg::prcc_req_t req_in,
  input  wire logic          valid_in,
  input  wire logic [31:0]   abort_in,
  output logic               ready_out,
  output logic               done_out,
  output logic [4:0]         done_ch_out,
  // Bookkeeping for the bench
  output logic [15:0]        taken_out,
  output prcc_pkg::prcc_req_t last_out,
  output logic [15:0]        clash_out
);
  import prcc_pkg::*;
  logic [4:0]  pend[$];
  logic [15:0] age;
  assign ready_out = !stall_in;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend.delete();
      age         <= '0;
      done_out    <= 1'b0;
      done_ch_out <= '0;
      taken_out   <= '0;
      last_out    <= '0;
      clash_out   <= '0;
    end else begin
      done_out    <= 1'b0;
      // Channel line shows junk outside a done pulse
      done_ch_out <= ~done_ch_out;
      for (int i = pend.size() - 1; i >= 0; i--)
        if (abort_in[pend[i]]) pend.delete(i);
      if (pend.size() == 0) age <= '0;
      else if (age >= lat_in) begin
        done_out    <= 1'b1;
        done_ch_out <= pend[0];
        pend.pop_front();
        age         <= '0;
      end else age <= age + 16'h1;
      if (valid_in && ready_out) begin
        foreach (pend[i]) if (pend[i] == req_in.channel) clash_out <= clash_out + 16'h1;
        pend.push_back(req_in.channel);
        taken_out <= taken_out + 16'h1;
        last_out  <= req_in;
      end
    end
  end
endmodule // prcc_engine_model
`default_nettype wire

// file: sim/periodic_report_channel_control_tb_top.sv
// Self-checking bench of the periodic report channel controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end
module periodic_report_channel_control_tb_top;
  import prcc_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, valid, ready, done, stall, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, abort, abort_seen, q;
  logic [4:0]  done_ch;
  logic [15:0] lat, taken, clash, b;
  prcc_req_t   req, last;
  int          error_cnt = 0, checks_done = 0, cyc = 0, k;

  prcc_top #(.TICK_CYCLES(16)) prcc_top_i (.REF_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .XFER_REQ_OUT(req), .XFER_VALID_OUT(valid), .XFER_READY_IN(ready),
    .XFER_DONE_IN(done), .XFER_DONE_CH_IN(done_ch), .XFER_ABORT_OUT(abort));
  prcc_engine_model prcc_engine_model_i (.clk_in(clk), .rst_in(rst), .lat_in(lat), .stall_in(stall),
    .req_in(req), .valid_in(valid), .abort_in(abort), .ready_out(ready), .done_out(done),
    .done_ch_out(done_ch), .taken_out(taken), .last_out(last), .clash_out(clash));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (abort !== 32'h0) abort_seen <= abort_seen | abort;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for pready, which rises with penable; the bench timeout ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, x, input string s);
    apb(1'b0, a, 32'h0);
    `CHK(s, x, q & m)
  endtask

  task automatic det_chk(input int ch, input logic [31:0] m, x, input string s);
    apb(1'b1, OFF_DSEL, 32'(ch));
    rd_chk(OFF_DETAIL, m, x, s);
  endtask

  task automatic setup(input int ch, rep, unit, cnt, tmo, mt, len, st, input logic [15:0] x);
    logic [15:0] w[17];
    w = '{CMD_SETUP, 16'(ch), 16'(rep), 16'(unit), 16'(cnt), 16'(tmo), 16'(mt), 16'(st), 16'(len),
          16'h0, 16'h0, ADDR_TYPE_IP, ADDR_LEN_IP, 16'h3, 16'h0, 16'h0, 16'h1};
    foreach (w[i]) apb(1'b1, 8'(4 * i), {16'h0, w[i]});
    apb(1'b1, OFF_GO, 32'h0);
    rd_chk(OFF_STATUS, 32'hffff, {16'h0, x}, "setup status");
  endtask

  task automatic abort_ch(input logic [15:0] ch);
    // Cleared off the edge so the pulse monitor cannot restore it
    @(negedge clk);
    abort_seen = '0;
    apb(1'b1, OFF_WORD0, {16'h0, CMD_ABORT});
    apb(1'b1, 8'h04, {16'h0, ch});
    apb(1'b1, OFF_GO, 32'h0);
    rd_chk(OFF_STATUS, 32'hffff, {16'h0, STAT_OK}, "abort status");
  endtask

  task automatic wait_taken(input logic [15:0] n, input int lim);
    k = 0;
    while (taken !== n && k < lim) begin
      @(posedge clk);
      k++;
    end
    `CHK("transfers taken", n, taken)
  endtask

  task automatic t_reset();
    rd_chk(OFF_STATUS, 32'hffffffff, 32'h0, "status after reset");
    rd_chk(OFF_CTRL, 32'h200, 32'h0, "error bit after reset");
    rd_chk(8'h60, 32'hffffffff, 32'h0, "unmapped read");
    `CHK("unmapped error", 1'b1, e)
    $display("test reset done");
  endtask

  task automatic t_params();
    int mt[24] = '{0, 4, 6, 8, 10, 12, 16, 18, 20, 22, 24, 26, 28, 30, 56, 70, 72, 74, 76, 78, 80, 82, 84, 86};
    int lim;
    logic ok;
    foreach (mt[i]) begin
      lim = mt[i] < 16 ? 1024 : mt[i] < 70 ? 2048 : 16384;
      ok = mt[i] > 6;
      b = taken;
      setup(1, 1, 1, 0, 0, mt[i], lim, 1, ok ? STAT_OK : STAT_PARAM_ERR);
      if (ok) begin
        wait_taken(b + 16'd1, 10);
        `CHK("memory type", 8'(mt[i]), last.mem_type)
        `CHK("length", 16'(lim), last.length)
      end
    end
    setup(1, 1, 1, 0, 0, 8, 1025, 1, STAT_PARAM_ERR);
    setup(0, 1, 1, 0, 0, 8, 1, 1, STAT_CMD_ERR);
    setup(33, 1, 1, 0, 0, 8, 1, 1, STAT_CMD_ERR);
    setup(2, 1, 6, 1, 0, 8, 1, 1, STAT_PARAM_ERR);
    $display("test params done");
  endtask

  task automatic t_period();
    lat   <= 16'd5;
    stall <= 1'b1;
    b = taken;
    setup(3, 2, UNIT_TENTH, 1, 0, MT_R, 8, 5, STAT_OK);
    `CHK("request stands", 1'b1, valid)
    stall <= 1'b0;
    wait_taken(b + 16'd1, 8);
    `CHK("channel index", 5'd2, last.channel)
    `CHK("zero based start", 16'd4, last.start)
    `CHK("server address", 32'h03000001, last.ip)
    wait_taken(b + 16'd2, 200);
    `CHK("period length", 1'b1, (k > 140 && k < 166))
    repeat (20) @(posedge clk);
    rd_chk(OFF_XFER, 32'h4, 32'h4, "transfer bit");
    rd_chk(OFF_XFER, 32'h4, 32'h0, "transfer bit cleared");
    repeat (200) @(posedge clk);
    `CHK("closed after count", b + 16'd2, taken)
    det_chk(3, 32'h10000, 32'h0, "closed channel idle");
    $display("test period done");
  endtask

  task automatic t_late();
    lat <= 16'd80;
    b = taken;
    setup(4, 0, UNIT_HUNDREDTH, 2, 0, MT_R, 1, 1, STAT_OK);
    wait_taken(b + 16'd1, 8);
    repeat (50) @(posedge clk);
    `CHK("no send while pending", b + 16'd1, taken)
    rd_chk(OFF_CTRL, 32'h200, 32'h200, "controller error bit");
    rd_chk(OFF_ERR, 32'h8, 32'h8, "channel error bit");
    det_chk(4, 32'hffff, {16'h0, DET_PERIOD_ERR}, "period error code");
    wait_taken(b + 16'd2, 60);
    abort_ch(16'd4);
    `CHK("abort pulse", 32'h8, abort_seen)
    `CHK("request dropped", 1'b0, valid)
    rd_chk(OFF_CTRL, 32'h200, 32'h0, "error bit after abort");
    rd_chk(OFF_ERR, 32'h8, 32'h0, "channel error after abort");
    rd_chk(OFF_XFER, 32'h8, 32'h0, "transfer bit after abort");
    det_chk(4, 32'h1ffff, 32'h0, "detail after abort");
    b = taken;
    repeat (100) @(posedge clk);
    `CHK("no traffic after abort", b, taken)
    $display("test late done");
  endtask

  task automatic t_timeout();
    lat <= 16'd60;
    b = taken;
    setup(5, 1, UNIT_SEC, 1, 2, MT_R, 1, 1, STAT_OK);
    wait_taken(b + 16'd1, 8);
    repeat (45) @(posedge clk);
    rd_chk(OFF_CTRL, 32'h200, 32'h200, "timeout error bit");
    det_chk(5, 32'h1ffff, {16'h1, DET_TMO_ERR}, "timeout code");
    repeat (60) @(posedge clk);
    det_chk(5, 32'h10000, 32'h10000, "active through period");
    `CHK("single send", b + 16'd1, taken)
    abort_ch(CHAN_ALL);
    `CHK("abort all pulse", 1'b1, abort_seen[4])
    abort_ch(CHAN_ALL);
    abort_ch(16'd9);
    $display("test timeout done");
  endtask

  task automatic t_reassign();
    lat <= 16'd3;
    b = taken;
    setup(7, 0, UNIT_HOUR, 1, 0, MT_R, 1, 1, STAT_OK);
    wait_taken(b + 16'd1, 8);
    repeat (20) @(posedge clk);
    setup(7, 2, UNIT_HUNDREDTH, 0, 0, MT_R, 1, 9, STAT_OK);
    wait_taken(b + 16'd3, 20);
    `CHK("new start", 16'd8, last.start)
    repeat (100) @(posedge clk);
    `CHK("closed after count", b + 16'd3, taken)
    rd_chk(OFF_CTRL, 32'h200, 32'h0, "no period error");
    $display("test reassign done");
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lat = 16'd2;
    stall = 1'b0;
    abort_seen = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_params();
    t_period();
    t_late();
    t_timeout();
    t_reassign();
    `CHK("one outstanding per channel", 16'h0, clash)
    report_and_stop();
  end
endmodule // periodic_report_channel_control_tb_top
`default_nettype wire
